// *** verilog/sdram_init_refresh_pkg.sv ***
// constants for the sdram init sequencer and refresh scheduler
// assumes a single clock domain at ref_clk_i; memory clock sampled as a pin
package sdram_init_refresh_pkg;
  localparam int unsigned INTERVAL_W = 13;
  localparam int unsigned BACKLOG_W = 4;
  localparam logic [3:0] BACKLOG_MAX = 4'hF;
  localparam logic [3:0] INIT_INTERVALS = 4'h8;
  localparam logic [3:0] INIT_REFRESHES = 4'h8;
  localparam logic [3:0] MAY_LO = 4'h1;
  localparam logic [3:0] RELEASE_LO = 4'h4;
  localparam logic [3:0] NEED_LO = 4'h8;
  localparam logic [3:0] MUST_LO = 4'hC;
  localparam logic [2:0] BURST_LEN_CODE = 3'h3;
  localparam int unsigned DRIVE_LSB = 5;
  localparam int unsigned CAS_LSB = 4;
  localparam int unsigned PRECHARGE_ALL_BIT = 10;
  localparam logic [12:0] REFRESH_PERIOD_RST = 13'h0080;
  // command codes {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_NOP = 3'h7;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_LMR = 3'h0;
  localparam logic [1:0] BA_MODE = 2'h0;
  localparam logic [1:0] BA_EXT_MODE = 2'h2;
endpackage

// *** verilog/sdram_down_counter.sv ***
// loadable down counter that reloads itself at zero
// assumes a synchronous active-high reset and a clock enable
`timescale 1ns/1ps
`default_nettype none
module sdram_down_counter #(
  parameter int unsigned WIDTH = 13
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic step_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] value_i,
  output logic reload_o
);
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic reload_q;
  logic reload_d;

  always_comb begin
    count_d = count_q;
    reload_d = 1'b0;
    if (sys_rst_i || load_i) begin
      count_d = value_i;
    end else if (step_i) begin
      if (count_q == '0) begin
        count_d = value_i;
        reload_d = 1'b1;
      end else begin
        count_d = count_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    count_q <= count_d;
    reload_q <= reload_d;
  end

  assign reload_o = reload_q;
endmodule
`default_nettype wire

// *** verilog/sdram_init_refresh_ctrl.sv ***
// sdram power-up/re-init sequencer and auto-refresh scheduler
// assumes config write strobes come from the host on ref_clk_i; memory clock is a pin
`timescale 1ns/1ps
`default_nettype none
module sdram_init_refresh_ctrl #(
  parameter int unsigned PERIOD_W = sdram_init_refresh_pkg::INTERVAL_W
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic memory_clock_i,
  input wire logic [PERIOD_W-1:0] refresh_period_field_i,
  input wire logic refresh_period_wr_i,
  input wire logic sdram_config_one_wr_i,
  input wire logic sdram_config_two_lo_wr_i,
  input wire logic sdram_config_two_hi_wr_i,
  input wire logic [2:0] cas_latency_field_i,
  input wire logic [1:0] drive_strength_i,
  input wire logic [2:0] partial_array_setting_i,
  input wire logic [3:0] refresh_cycle_time_i,
  input wire logic self_refresh_active_i,
  input wire logic req_pending_i,
  input wire logic read_pending_i,
  input wire logic access_busy_i,
  input wire logic banks_open_i,
  output logic init_done_o,
  output logic access_allow_o,
  output logic mem_clock_enable_pin_o,
  output logic cmd_valid_o,
  output logic [2:0] cmd_o,
  output logic [1:0] bank_select_pins_o,
  output logic [15:0] mem_addr_o,
  output logic [3:0] backlog_o
);
  typedef enum logic [7:0] {
    ST_WAIT = 8'h01,
    ST_INIT_PRE = 8'h02,
    ST_INIT_REF = 8'h04,
    ST_EMR = 8'h08,
    ST_MR = 8'h10,
    ST_IDLE = 8'h20,
    ST_REF_PRE = 8'h40,
    ST_REF_WAIT = 8'h80
  } state_e;

  state_e state_q, state_d;
  logic [2:0] clk_sync_q, clk_sync_d;
  logic [3:0] icount_q, icount_d;
  logic [3:0] twait_q, twait_d;
  logic [3:0] backlog_q, backlog_d;
  logic final_ref_q, final_ref_d;
  logic done_q, done_d;
  logic allow_q, allow_d;
  logic cke_q, cke_d;
  logic vld_q, vld_d;
  logic [2:0] cmd_q, cmd_d;
  logic [1:0] ba_q, ba_d;
  logic [15:0] addr_q, addr_d;
  logic mclk_rise;
  logic reload;
  logic issue_ref;
  logic start_ref;
  logic restart;

  // memory clock passes two flops before its edge is found
  assign mclk_rise = clk_sync_q[1] && !clk_sync_q[2];
  // upper byte write deliberately has no path here
  assign restart = sdram_config_one_wr_i || sdram_config_two_lo_wr_i;

  sdram_down_counter #(
    .WIDTH(PERIOD_W)
  ) u_interval (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .step_i(clk_en_i && mclk_rise && !self_refresh_active_i),
    .load_i(clk_en_i && refresh_period_wr_i),
    .value_i(refresh_period_field_i),
    .reload_o(reload)
  );

  // urgency decision, never masked by any setting
  always_comb begin
    start_ref = 1'b0;
    if (backlog_q >= sdram_init_refresh_pkg::MUST_LO) begin
      start_ref = !access_busy_i;
    end else if (backlog_q >= sdram_init_refresh_pkg::NEED_LO) begin
      start_ref = !access_busy_i && !read_pending_i;
    end else if (backlog_q >= sdram_init_refresh_pkg::RELEASE_LO) begin
      start_ref = !req_pending_i && !access_busy_i;
    end else if (backlog_q >= sdram_init_refresh_pkg::MAY_LO) begin
      start_ref = !req_pending_i && !access_busy_i && !banks_open_i;
    end
  end

  always_comb begin
    clk_sync_d = {clk_sync_q[1:0], memory_clock_i};
    state_d = state_q;
    icount_d = icount_q;
    twait_d = twait_q;
    final_ref_d = final_ref_q;
    done_d = done_q;
    allow_d = allow_q;
    cke_d = 1'b1;
    vld_d = 1'b0;
    cmd_d = sdram_init_refresh_pkg::CMD_NOP;
    ba_d = ba_q;
    addr_d = addr_q;
    issue_ref = 1'b0;
    // reload pulse lags the memory clock rise by one cycle, so count it on its own
    if (state_q == ST_WAIT && reload) begin
      icount_d = icount_q + 4'h1;
    end
    if (restart) begin
      state_d = ST_INIT_PRE;
      done_d = 1'b0;
      allow_d = 1'b0;
      icount_d = '0;
      final_ref_d = 1'b0;
    end else if (mclk_rise) begin
      vld_d = 1'b1;
      case (state_q)
        ST_WAIT: begin
          if (icount_q == sdram_init_refresh_pkg::INIT_INTERVALS) begin
            state_d = ST_INIT_PRE;
            icount_d = '0;
          end
        end
        ST_INIT_PRE, ST_REF_PRE: begin
          cmd_d = sdram_init_refresh_pkg::CMD_PRE;
          addr_d = '0;
          addr_d[sdram_init_refresh_pkg::PRECHARGE_ALL_BIT] = 1'b1;
          ba_d = '0;
          if (state_q == ST_INIT_PRE) begin
            state_d = ST_INIT_REF;
          end else begin
            state_d = ST_REF_WAIT;
            twait_d = '0;
          end
        end
        ST_INIT_REF: begin
          cmd_d = sdram_init_refresh_pkg::CMD_REF;
          issue_ref = 1'b1;
          icount_d = icount_q + 4'h1;
          if (icount_q == sdram_init_refresh_pkg::INIT_REFRESHES - 4'h1) begin
            state_d = ST_EMR;
          end
        end
        ST_EMR: begin
          cmd_d = sdram_init_refresh_pkg::CMD_LMR;
          ba_d = sdram_init_refresh_pkg::BA_EXT_MODE;
          addr_d = '0;
          addr_d[sdram_init_refresh_pkg::DRIVE_LSB +: 2] = drive_strength_i;
          addr_d[2:0] = partial_array_setting_i;
          state_d = ST_MR;
        end
        ST_MR: begin
          cmd_d = sdram_init_refresh_pkg::CMD_LMR;
          ba_d = sdram_init_refresh_pkg::BA_MODE;
          addr_d = '0;
          addr_d[sdram_init_refresh_pkg::CAS_LSB +: 3] = cas_latency_field_i;
          addr_d[2:0] = sdram_init_refresh_pkg::BURST_LEN_CODE;
          final_ref_d = 1'b1;
          state_d = ST_REF_PRE;
        end
        ST_IDLE: begin
          allow_d = 1'b1;
          if (start_ref) begin
            state_d = ST_REF_PRE;
            allow_d = 1'b0;
          end
        end
        ST_REF_WAIT: begin
          if (twait_q == '0) begin
            cmd_d = sdram_init_refresh_pkg::CMD_REF;
            issue_ref = 1'b1;
          end
          twait_d = twait_q + 4'h1;
          // compare before the 4-bit wait count can wrap
          if (twait_q >= refresh_cycle_time_i) begin
            if (final_ref_q) begin
              final_ref_d = 1'b0;
              done_d = 1'b1;
              state_d = ST_IDLE;
            end else if (backlog_q >= sdram_init_refresh_pkg::NEED_LO) begin
              state_d = ST_REF_PRE;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        default: begin
          state_d = ST_WAIT;
        end
      endcase
    end
    if (!done_d) begin
      allow_d = 1'b0;
    end
  end

  always_comb begin
    backlog_d = backlog_q;
    if (!self_refresh_active_i) begin
      if (reload && !issue_ref && backlog_q != sdram_init_refresh_pkg::BACKLOG_MAX) begin
        backlog_d = backlog_q + 4'h1;
      end else if (issue_ref && !reload && backlog_q != '0) begin
        backlog_d = backlog_q - 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_q <= ST_WAIT;
      clk_sync_q <= '0;
      icount_q <= '0;
      twait_q <= '0;
      backlog_q <= '0;
      final_ref_q <= 1'b0;
      done_q <= 1'b0;
      allow_q <= 1'b0;
      cke_q <= 1'b1;
      vld_q <= 1'b0;
      cmd_q <= sdram_init_refresh_pkg::CMD_NOP;
      ba_q <= '0;
      addr_q <= '0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      clk_sync_q <= clk_sync_d;
      icount_q <= icount_d;
      twait_q <= twait_d;
      backlog_q <= backlog_d;
      final_ref_q <= final_ref_d;
      done_q <= done_d;
      allow_q <= allow_d;
      cke_q <= cke_d;
      vld_q <= vld_d;
      cmd_q <= cmd_d;
      ba_q <= ba_d;
      addr_q <= addr_d;
    end
  end

  assign init_done_o = done_q;
  assign access_allow_o = allow_q;
  assign mem_clock_enable_pin_o = cke_q;
  assign cmd_valid_o = vld_q;
  assign cmd_o = cmd_q;
  assign bank_select_pins_o = ba_q;
  assign mem_addr_o = addr_q;
  assign backlog_o = backlog_q;
endmodule
`default_nettype wire

// *** sim/sdram_init_refresh_props.sv ***
// checker for the sdram init sequencer and refresh scheduler
// assumes it is bound to the controller and sees its ports only
`timescale 1ns/1ps
`default_nettype none
module sdram_init_refresh_props (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [2:0] cas_latency_field_i,
  input wire logic [1:0] drive_strength_i,
  input wire logic [2:0] partial_array_setting_i,
  input wire logic self_refresh_active_i,
  input wire logic init_done_o,
  input wire logic access_allow_o,
  input wire logic mem_clock_enable_pin_o,
  input wire logic cmd_valid_o,
  input wire logic [2:0] cmd_o,
  input wire logic [1:0] bank_select_pins_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic [3:0] backlog_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [2:0] last_cmd_d;
  logic [2:0] last_cmd_q;
  wire load_mode_cmd = cmd_valid_o && cmd_o == sdram_init_refresh_pkg::CMD_LMR;
  // last command other than nop
  always_comb begin
    last_cmd_d = last_cmd_q;
    if (cmd_valid_o && cmd_o != sdram_init_refresh_pkg::CMD_NOP) begin
      last_cmd_d = cmd_o;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    last_cmd_q <= sys_rst_i ? sdram_init_refresh_pkg::CMD_NOP : last_cmd_d;
  end
  cke_high_a: assert property (mem_clock_enable_pin_o)
    else $error("clock enable low");
  no_early_a: assert property (!init_done_o |-> !access_allow_o)
    else $error("access before init");
  pre_all_a: assert property (cmd_valid_o && cmd_o == 3'h2 |-> mem_addr_o[10])
    else $error("precharge not to all banks");
  ext_mode_a: assert property (load_mode_cmd && bank_select_pins_o == 2'h2
    |-> mem_addr_o == {9'h000, drive_strength_i, 2'h0, partial_array_setting_i})
    else $error("extended mode value");
  mode_reg_a: assert property (load_mode_cmd && bank_select_pins_o == 2'h0
    |-> mem_addr_o == {9'h000, cas_latency_field_i, 4'h3})
    else $error("mode value");
  ref_after_pre_a: assert property (init_done_o && cmd_valid_o && cmd_o == 3'h1
    |-> last_cmd_q == 3'h2) else $error("refresh without precharge");
  done_by_ref_a: assert property ($rose(init_done_o) |-> last_cmd_q == 3'h1)
    else $error("init ended without refresh");
  backlog_step_a: assert property (!$past(sys_rst_i) && backlog_o != $past(backlog_o)
    |-> backlog_o == $past(backlog_o) + 4'h1 && backlog_o != 4'h0
    || backlog_o + 4'h1 == $past(backlog_o) && backlog_o != 4'hF) else $error("backlog step");
  frozen_a: assert property (self_refresh_active_i && $past(self_refresh_active_i)
    && !$past(sys_rst_i) |-> backlog_o == $past(backlog_o)) else $error("backlog moved");
  cover property ($rose(init_done_o));
  cover property (backlog_o == 4'hF);
  cover property (load_mode_cmd);
endmodule
bind sdram_init_refresh_ctrl sdram_init_refresh_props props_inst (.ref_clk_i, .sys_rst_i,
  .cas_latency_field_i, .drive_strength_i, .partial_array_setting_i, .self_refresh_active_i,
  .init_done_o, .access_allow_o, .mem_clock_enable_pin_o, .cmd_valid_o, .cmd_o,
  .bank_select_pins_o, .mem_addr_o, .backlog_o);
`default_nettype wire

// *** sim/sdram_cmd_sink.sv ***
// sdram device model: logs every command other than nop that it is given
// assumes commands are qualified by a one-cycle valid pulse
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_sink (
  input wire logic clk_i,
  input wire logic valid_i,
  input wire logic [2:0] cmd_i,
  input wire logic [1:0] ba_i,
  input wire logic [15:0] addr_i
);
  logic [20:0] log_q[$];
  always @(posedge clk_i) begin
    if (valid_i === 1'b1 && cmd_i !== 3'h7) begin
      log_q.push_back({cmd_i, ba_i, addr_i});
    end
  end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// testbench for the sdram init sequencer and refresh scheduler
// assumes the checker is bound in and the command log model is present
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic ref_clk_i, sys_rst_i, memory_clock_i, refresh_period_wr_i, sdram_config_one_wr_i;
  logic sdram_config_two_lo_wr_i, sdram_config_two_hi_wr_i, self_refresh_active_i;
  logic req_pending_i, read_pending_i, access_busy_i, banks_open_i;
  logic clk_en_i = 1'b1;
  logic [12:0] refresh_period_field_i;
  logic [2:0] cas_latency_field_i, partial_array_setting_i;
  logic [1:0] drive_strength_i, bank_select_pins_o;
  logic [3:0] refresh_cycle_time_i, backlog_o;
  logic init_done_o, access_allow_o, mem_clock_enable_pin_o, cmd_valid_o;
  logic [2:0] cmd_o;
  logic [15:0] mem_addr_o;
  int n_fail = 0, n_compared = 0, cyc = 0, k, e;
  sdram_init_refresh_ctrl sdram_init_refresh_ctrl_inst (.ref_clk_i, .sys_rst_i, .clk_en_i,
    .memory_clock_i, .refresh_period_field_i, .refresh_period_wr_i, .sdram_config_one_wr_i,
    .sdram_config_two_lo_wr_i, .sdram_config_two_hi_wr_i, .cas_latency_field_i,
    .drive_strength_i, .partial_array_setting_i, .refresh_cycle_time_i, .self_refresh_active_i,
    .req_pending_i, .read_pending_i, .access_busy_i, .banks_open_i, .init_done_o,
    .access_allow_o, .mem_clock_enable_pin_o, .cmd_valid_o, .cmd_o, .bank_select_pins_o,
    .mem_addr_o, .backlog_o);
  sdram_cmd_sink sdram_cmd_sink_inst (.clk_i(ref_clk_i), .valid_i(cmd_valid_o), .cmd_i(cmd_o),
    .ba_i(bank_select_pins_o), .addr_i(mem_addr_o));
  initial begin
    ref_clk_i = 0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    memory_clock_i = 0;
    #137;
    forever #400 memory_clock_i = ~memory_clock_i;
  end
  task results;
    if (n_fail == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      results();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #5;
  endtask
  task chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1;
    tick(1);
    s = 0;
  endtask
  // expected init command order from the current settings
  task automatic cmp_init;
    logic [20:0] q[$];
    logic [20:0] m;
    q.push_back({3'h2, 18'h00400});
    repeat (8) q.push_back({3'h1, 18'h00000});
    q.push_back({5'h02, 9'h000, drive_strength_i, 2'h0, partial_array_setting_i});
    q.push_back({5'h00, 9'h000, cas_latency_field_i, 4'h3});
    q.push_back(q[0]);
    q.push_back(q[1]);
    for (int i = 0; i < 13; i++) begin
      m = (i == 9 || i == 10) ? 21'h1FFFFF : (i == 0 || i == 11) ? 21'h1C0400 : 21'h1C0000;
      chk((sdram_cmd_sink_inst.log_q[i] & m) === (q[i] & m), "init command order");
    end
  endtask
  initial begin
    void'($urandom(83690));
    {sys_rst_i, refresh_period_wr_i, sdram_config_one_wr_i, sdram_config_two_lo_wr_i} = 4'hF;
    {sdram_config_two_hi_wr_i, self_refresh_active_i, req_pending_i} = 3'h0;
    {read_pending_i, access_busy_i, banks_open_i, refresh_period_wr_i} = 4'h0;
    {sdram_config_one_wr_i, sdram_config_two_lo_wr_i} = 2'h0;
    refresh_period_field_i = 13'h0004;
    refresh_cycle_time_i = 4'h2;
    {drive_strength_i, partial_array_setting_i} = 5'($urandom);
    cas_latency_field_i = {2'h1, 1'($urandom)};
    tick(12);
    sys_rst_i = 0;
    tick(1);
    pulse(refresh_period_wr_i);
    for (k = 0; k < 12000 && init_done_o !== 1'b1; k++) tick(1);
    chk(init_done_o === 1'b1, "init not done");
    cmp_init();
    refresh_period_field_i = 13'h0028;
    pulse(refresh_period_wr_i);
    for (int j = 0; j < 2; j++) begin
      for (k = 0; k < 3000 && (backlog_o !== 4'h0 || access_allow_o !== 1'b1); k++) tick(1);
      sdram_cmd_sink_inst.log_q.delete();
      {drive_strength_i, partial_array_setting_i} = 5'($urandom);
      cas_latency_field_i = {2'h1, 1'($urandom)};
      if (j == 0) pulse(sdram_config_one_wr_i);
      else pulse(sdram_config_two_lo_wr_i);
      for (k = 0; k < 2000 && (sdram_cmd_sink_inst.log_q.size() < 13 || !init_done_o); k++) tick(1);
      cmp_init();
    end
    pulse(sdram_config_two_hi_wr_i);
    tick(100);
    chk(init_done_o === 1'b1, "upper byte write restarted");
    {req_pending_i, read_pending_i, access_busy_i} = 3'h7;
    tick(7000);
    e = 7000 / 328;
    if (e > 15) e = 15;
    chk(backlog_o === 4'(e), "backlog not saturated");
    access_busy_i = 0;
    for (k = 0; k < 2000 && backlog_o !== 4'h7; k++) tick(1);
    chk(backlog_o === 4'h7, "must level drain");
    for (k = 0; k < 200 && access_allow_o !== 1'b1; k++) tick(1);
    chk(access_allow_o === 1'b1, "no return to idle");
    {req_pending_i, read_pending_i} = 2'h0;
    for (k = 0; k < 3000 && backlog_o !== 4'h0; k++) tick(1);
    chk(backlog_o === 4'h0, "release level drain");
    banks_open_i = 1;
    for (k = 0; k < 1000 && backlog_o !== 4'h1; k++) tick(1);
    tick(200);
    chk(backlog_o === 4'h1, "refresh with banks open");
    clk_en_i = 0;
    tick(700);
    chk(backlog_o === 4'h1, "state ran with clock enable low");
    clk_en_i = 1;
    self_refresh_active_i = 1;
    tick(800);
    chk(backlog_o === 4'h1, "counters ran in self refresh");
    {self_refresh_active_i, banks_open_i} = 2'h0;
    for (k = 0; k < 1000 && backlog_o !== 4'h0; k++) tick(1);
    chk(backlog_o === 4'h0, "refresh did not decrement");
    results();
  end
endmodule
`default_nettype wire
